// *** design/dal_loader.sv ***
// serial input and load control of a dual 8-bit converter.
// assumes a three-wire host link (frame select low, clock, data) slower than clock.
`timescale 1ns/100ps

module dal_loader
	import dal_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic din,
	output logic [7:0] dac_a_code,
	output logic [7:0] dac_b_code,
	output logic ref_source_sel,
	output logic powerdown_chan_a,
	output logic powerdown_chan_b,
	output logic bias_enable,
	output logic chan_a_ready,
	output logic chan_b_ready,
	output logic latch_transparent,
	output logic word_done,
	output logic word_discard
);

	dal_regs_t r_reg;
	dal_regs_t r_next;
	dal_word_t w;
	logic sclk_rise;
	logic sync_fall;
	logic sync_rise;
	logic exec_go;

	assign w = dal_word_t'(r_reg.shift);
	assign sclk_rise = r_reg.sclk_s2 & ~r_reg.sclk_d;
	assign sync_fall = r_reg.sync_d & ~r_reg.sync_s2;
	assign sync_rise = ~r_reg.sync_d & r_reg.sync_s2;
	assign exec_go = (r_reg.st == ST_FRAME) && sync_rise && (r_reg.cnt == WORD_BITS);

	always_comb begin
		r_next = r_reg;
		r_next.exec = 1'b0;
		r_next.discard = 1'b0;
		// pins cross into the clock domain through two flops each
		r_next.sclk_s1 = sclk;
		r_next.sclk_s2 = r_reg.sclk_s1;
		r_next.sclk_d = r_reg.sclk_s2;
		r_next.sync_s1 = sync_n;
		r_next.sync_s2 = r_reg.sync_s1;
		r_next.sync_d = r_reg.sync_s2;
		r_next.din_s1 = din;
		r_next.din_s2 = r_reg.din_s1;
		if (r_reg.rec_a != 9'h000) begin
			r_next.rec_a = r_reg.rec_a - 9'h001;
		end
		if (r_reg.rec_b != 9'h000) begin
			r_next.rec_b = r_reg.rec_b - 9'h001;
		end
		case (r_reg.st)
			ST_IDLE: begin
				if (sync_fall) begin
					r_next.st = ST_FRAME;
					r_next.cnt = 5'h00;
				end
			end
			ST_FRAME: begin
				if (sclk_rise) begin
					r_next.shift = {r_reg.shift[14:0], r_reg.din_s2};
					// saturate so a long frame cannot wrap back to sixteen
					if (r_reg.cnt != CNT_MAX) begin
						r_next.cnt = r_reg.cnt + 5'h01;
					end
				end
				if (sync_rise) begin
					r_next.st = ST_IDLE;
					if (exec_go) begin
						r_next.exec = 1'b1;
						r_next.transparent = 1'b0;
						r_next.ref_ext = w.ref_source_sel;
						r_next.pd_a = w.powerdown_chan_a;
						r_next.pd_b = w.powerdown_chan_b;
						// wake time depends on whether the bias was off too
						if (r_reg.pd_a && !w.powerdown_chan_a) begin
							r_next.rec_a = (r_reg.pd_b) ? REC_FULL_CYC : REC_PART_CYC;
						end else if (w.powerdown_chan_a) begin
							r_next.rec_a = 9'h000;
						end
						if (r_reg.pd_b && !w.powerdown_chan_b) begin
							r_next.rec_b = (r_reg.pd_a) ? REC_FULL_CYC : REC_PART_CYC;
						end else if (w.powerdown_chan_b) begin
							r_next.rec_b = 9'h000;
						end
						if (w.sync_load_both) begin
							if (w.chan_b_sel) begin
								r_next.in_b = w.data;
							end else begin
								r_next.in_a = w.data;
							end
							r_next.conv_a = r_next.in_a;
							r_next.conv_b = r_next.in_b;
						end else begin
							case ({w.load_op_hi, w.load_op_lo})
								OP_BOTH_DIRECT: begin
									r_next.conv_a = w.data;
									r_next.conv_b = w.data;
								end
								OP_INPUT_ONLY: begin
									if (w.chan_b_sel) begin
										r_next.in_b = w.data;
									end else begin
										r_next.in_a = w.data;
									end
								end
								OP_INPUT_TO_CONV: begin
									if (w.chan_b_sel) begin
										r_next.conv_b = r_reg.in_b;
									end else begin
										r_next.conv_a = r_reg.in_a;
									end
								end
								default: begin
									if (w.chan_b_sel) begin
										r_next.conv_b = w.data;
									end else begin
										r_next.conv_a = w.data;
									end
								end
							endcase
						end
					end else begin
						r_next.discard = 1'b1;
					end
				end
			end
			default: begin
				r_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			r_reg <= RST_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	// power-down only gates the analog side, registers stay as they are
	assign dac_a_code = r_reg.conv_a;
	assign dac_b_code = r_reg.conv_b;
	assign ref_source_sel = r_reg.ref_ext;
	assign powerdown_chan_a = r_reg.pd_a;
	assign powerdown_chan_b = r_reg.pd_b;
	assign bias_enable = ~(r_reg.pd_a & r_reg.pd_b);
	assign chan_a_ready = ~r_reg.pd_a && (r_reg.rec_a == 9'h000);
	assign chan_b_ready = ~r_reg.pd_b && (r_reg.rec_b == 9'h000);
	assign latch_transparent = r_reg.transparent;
	assign word_done = r_reg.exec;
	assign word_discard = r_reg.discard;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_idle_hold;
		(r_reg.st == ST_IDLE) |=> $stable(r_reg.shift);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("shift moved outside a frame");

	property p_shift_in;
		(r_reg.st == ST_FRAME && sclk_rise) |=> (r_reg.shift == {$past(r_reg.shift[14:0]), $past(r_reg.din_s2)});
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("serial bit not captured");

	property p_restart;
		(r_reg.st == ST_IDLE && sync_fall) |=> (r_reg.cnt == 5'h00 && r_reg.st == ST_FRAME);
	endproperty
	a_restart: assert property (p_restart) else $error("bit counter not restarted");

	property p_exec_count;
		word_done |-> ($past(r_reg.cnt) == WORD_BITS && $past(sync_rise));
	endproperty
	a_exec_count: assert property (p_exec_count) else $error("executed without sixteen bits");

	property p_discard;
		(r_reg.st == ST_FRAME && sync_rise && r_reg.cnt != WORD_BITS) |=>
			($stable(r_reg.conv_a) && $stable(r_reg.conv_b) && $stable(r_reg.in_a) && $stable(r_reg.in_b)
			&& $stable(r_reg.pd_a) && $stable(r_reg.pd_b) && $stable(r_reg.ref_ext) && word_discard);
	endproperty
	a_discard: assert property (p_discard) else $error("short word changed state");

	property p_ref;
		word_done |-> (ref_source_sel == $past(r_reg.shift[15]));
	endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");

	property p_both_direct;
		(exec_go && !w.sync_load_both && {w.load_op_hi, w.load_op_lo} == OP_BOTH_DIRECT) |=>
			(dac_a_code == $past(w.data) && dac_b_code == $past(w.data));
	endproperty
	a_both_direct: assert property (p_both_direct) else $error("both-channel direct load wrong");

	property p_input_only;
		(exec_go && !w.sync_load_both && {w.load_op_hi, w.load_op_lo} == OP_INPUT_ONLY) |=>
			($stable(r_reg.conv_a) && $stable(r_reg.conv_b));
	endproperty
	a_input_only: assert property (p_input_only) else $error("input write touched output");

	property p_sync_load;
		(exec_go && w.sync_load_both) |=> (r_reg.conv_a == r_reg.in_a && r_reg.conv_b == r_reg.in_b
			&& (r_reg.conv_b == $past(w.data) || !$past(w.chan_b_sel)));
	endproperty
	a_sync_load: assert property (p_sync_load) else $error("synchronous load wrong");

	property p_full_wake;
		(exec_go && r_reg.pd_a && r_reg.pd_b && !w.powerdown_chan_a) |=> !chan_a_ready [*8];
	endproperty
	a_full_wake: assert property (p_full_wake) else $error("channel a ready too soon");

	property p_bias_off;
		(exec_go && w.powerdown_chan_a && w.powerdown_chan_b) |=> !bias_enable ##0 !chan_b_ready;
	endproperty
	a_bias_off: assert property (p_bias_off) else $error("bias left on");

	property p_power_on;
		latch_transparent |-> (dac_a_code == 8'h00 && dac_b_code == 8'h00 && r_reg.in_a == 8'h00 && r_reg.in_b == 8'h00);
	endproperty
	a_power_on: assert property (p_power_on) else $error("outputs not zero before first write");

	property p_input_target;
		(exec_go && !w.sync_load_both && {w.load_op_hi, w.load_op_lo} == OP_INPUT_ONLY) |=>
			($past(w.chan_b_sel) ? (r_reg.in_b == $past(w.data)) : (r_reg.in_a == $past(w.data)));
	endproperty
	a_input_target: assert property (p_input_target) else $error("input register not written");

	property p_input_to_conv;
		(exec_go && !w.sync_load_both && {w.load_op_hi, w.load_op_lo} == OP_INPUT_TO_CONV) |=>
			($past(w.chan_b_sel) ? (dac_b_code == $past(r_reg.in_b)) : (dac_a_code == $past(r_reg.in_a)));
	endproperty
	a_input_to_conv: assert property (p_input_to_conv) else $error("input to converter copy wrong");

	property p_conv_direct;
		(exec_go && !w.sync_load_both && {w.load_op_hi, w.load_op_lo} == OP_CONV_DIRECT) |=>
			($past(w.chan_b_sel) ? (dac_b_code == $past(w.data)) : (dac_a_code == $past(w.data)));
	endproperty
	a_conv_direct: assert property (p_conv_direct) else $error("converter direct write wrong");

	property p_pd_pins;
		word_done |-> (powerdown_chan_a == $past(w.powerdown_chan_a)
			&& powerdown_chan_b == $past(w.powerdown_chan_b));
	endproperty
	a_pd_pins: assert property (p_pd_pins) else $error("power-down bits wrong");

	property p_regs_hold;
		!exec_go |=> ($stable(r_reg.conv_a) && $stable(r_reg.conv_b) && $stable(r_reg.in_a) && $stable(r_reg.in_b));
	endproperty
	a_regs_hold: assert property (p_regs_hold) else $error("registers moved without a word");

	// partial wake must count out the short time, then come ready
	property p_part_wake;
		(exec_go && r_reg.pd_a && !r_reg.pd_b && !w.powerdown_chan_a) |=> !chan_a_ready [*8] ##25 chan_a_ready;
	endproperty
	a_part_wake: assert property (p_part_wake) else $error("channel a partial wake time wrong");

	property p_full_count;
		(exec_go && r_reg.pd_a && r_reg.pd_b && !w.powerdown_chan_a) |=> ##259 !chan_a_ready;
	endproperty
	a_full_count: assert property (p_full_count) else $error("channel a full wake too short");

	property p_pulse;
		(word_done || word_discard) |=> (!word_done && !word_discard);
	endproperty
	a_pulse: assert property (p_pulse) else $error("frame end pulse longer than one cycle");

	property p_idle_count;
		(r_reg.st == ST_IDLE && !sync_fall) |=> $stable(r_reg.cnt);
	endproperty
	a_idle_count: assert property (p_idle_count) else $error("bit count moved outside a frame");

endmodule

// *** design/dal_pkg.sv ***
// package for the dual converter serial loader: word layout, codes, timing, state.
// assumes a 20 MHz system clock and a slower serial link sampled by it.
package dal_pkg;

	localparam int CLK_PERIOD_NS = 50;
	localparam int T_REC_FULL_NS = 13000;
	localparam int T_REC_PART_NS = 1600;
	// least times, so round up to whole cycles
	localparam int REC_FULL_CYC_I = (T_REC_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_PART_CYC_I = (T_REC_PART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] REC_FULL_CYC = REC_FULL_CYC_I[8:0];
	localparam logic [8:0] REC_PART_CYC = REC_PART_CYC_I[8:0];

	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] CNT_MAX = 5'h1F;

	localparam logic [1:0] OP_BOTH_DIRECT = 2'h0;
	localparam logic [1:0] OP_INPUT_ONLY = 2'h1;
	localparam logic [1:0] OP_INPUT_TO_CONV = 2'h2;
	localparam logic [1:0] OP_CONV_DIRECT = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_FRAME = 2'h2
	} dal_state_e_t;

	// word as shifted, msb first
	typedef struct packed {
		logic ref_source_sel;
		logic spare;
		logic sync_load_both;
		logic powerdown_chan_b;
		logic powerdown_chan_a;
		logic chan_b_sel;
		logic load_op_hi;
		logic load_op_lo;
		logic [7:0] data;
	} dal_word_t;

	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_d;
		logic sync_s1;
		logic sync_s2;
		logic sync_d;
		logic din_s1;
		logic din_s2;
		dal_state_e_t st;
		logic [15:0] shift;
		logic [4:0] cnt;
		logic [7:0] in_a;
		logic [7:0] in_b;
		logic [7:0] conv_a;
		logic [7:0] conv_b;
		logic transparent;
		logic ref_ext;
		logic pd_a;
		logic pd_b;
		logic [8:0] rec_a;
		logic [8:0] rec_b;
		logic exec;
		logic discard;
	} dal_regs_t;

	localparam dal_regs_t RST_STATE = '{
		sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_d: 1'b0,
		sync_s1: 1'b1, sync_s2: 1'b1, sync_d: 1'b1,
		din_s1: 1'b0, din_s2: 1'b0,
		st: ST_IDLE, shift: 16'h0000, cnt: 5'h00,
		in_a: 8'h00, in_b: 8'h00, conv_a: 8'h00, conv_b: 8'h00,
		transparent: 1'b1, ref_ext: 1'b0, pd_a: 1'b0, pd_b: 1'b0,
		rec_a: 9'h000, rec_b: 9'h000, exec: 1'b0, discard: 1'b0
	};

endpackage

// *** dv/dal_host.sv ***
// host side model of the three-wire link: frame select, serial clock, data.
// assumes the bench clock at 20 MHz; the serial clock runs at 400 ns per bit.
`timescale 1ns/100ps
module dal_host (
	input wire logic clock,
	output logic sclk,
	output logic sync_n,
	output logic din
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		din = 1'b0;
	end
	task automatic half();
		repeat (4) @(negedge clock);
	endtask
	// n bits of w, msb first; split pauses between bytes with the frame still low
	task automatic send(input logic [31:0] w, input int n, input bit split);
		sync_n = 1'b0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			din = w[i];
			half();
			sclk = 1'b1;
			half();
			sclk = 1'b0;
			if (split && i == 8) begin
				repeat (4) half();
			end
		end
		half();
		sync_n = 1'b1;
		// released data line shows no stale value
		din = ~din;
		repeat (2) half();
	endtask
endmodule

// *** dv/tb_dual_dac_serial_loader.sv ***
// self-checking bench of the serial loader against a reference model.
// assumes dal_host drives the link; notes are compared at word_done or word_discard.
`timescale 1ns/100ps
module tb_dual_dac_serial_loader;
	import dal_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	wire logic sclk, sync_n, din;
	logic [7:0] dac_a_code, dac_b_code;
	logic ref_source_sel, powerdown_chan_a, powerdown_chan_b, bias_enable;
	logic chan_a_ready, chan_b_ready, latch_transparent, word_done, word_discard;
	int bad_count = 0;
	int n_checks = 0;
	logic [31:0] rnd = 32'hBEC0;
	logic [7:0] m_in_a = 8'h00, m_in_b = 8'h00, m_cv_a = 8'h00, m_cv_b = 8'h00;
	logic m_ref = 1'b0, m_pa = 1'b0, m_pb = 1'b0, m_tr = 1'b1;
	logic [21:0] notes[$];
	wire logic [21:0] obs = {word_discard, latch_transparent, bias_enable, ref_source_sel,
		powerdown_chan_a, powerdown_chan_b, dac_a_code, dac_b_code};
	always #25 clock = ~clock;
	dal_host h (.clock(clock), .sclk(sclk), .sync_n(sync_n), .din(din));
	dal_loader DUT (.clock(clock), .rst(rst), .sclk(sclk), .sync_n(sync_n), .din(din),
		.dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .ref_source_sel(ref_source_sel),
		.powerdown_chan_a(powerdown_chan_a), .powerdown_chan_b(powerdown_chan_b),
		.bias_enable(bias_enable), .chan_a_ready(chan_a_ready), .chan_b_ready(chan_b_ready),
		.latch_transparent(latch_transparent), .word_done(word_done), .word_discard(word_discard));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [21:0] state(input logic disc);
		return {disc, m_tr, ~(m_pa & m_pb), m_ref, m_pa, m_pb, m_cv_a, m_cv_b};
	endfunction
	task automatic chk(input logic [21:0] e, input logic [21:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_ready(input logic [1:0] e);
		n_checks++;
		if ({chan_a_ready, chan_b_ready} !== e) begin
			bad_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, {chan_a_ready, chan_b_ready});
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic word(input logic [15:0] w, input bit split);
		dal_word_t x;
		logic [7:0] d;
		x = w;
		d = x.data;
		if (x.sync_load_both) begin
			if (x.chan_b_sel) m_in_b = d;
			else m_in_a = d;
			m_cv_a = m_in_a;
			m_cv_b = m_in_b;
		end else begin
			case ({x.load_op_hi, x.load_op_lo})
				OP_BOTH_DIRECT: begin
					m_cv_a = d;
					m_cv_b = d;
				end
				OP_INPUT_ONLY: if (x.chan_b_sel) m_in_b = d; else m_in_a = d;
				OP_INPUT_TO_CONV: if (x.chan_b_sel) m_cv_b = m_in_b; else m_cv_a = m_in_a;
				default: if (x.chan_b_sel) m_cv_b = d; else m_cv_a = d;
			endcase
		end
		m_ref = x.ref_source_sel;
		m_pa = x.powerdown_chan_a;
		m_pb = x.powerdown_chan_b;
		m_tr = 1'b0;
		notes.push_back(state(1'b0));
		h.send({16'h0000, w}, 16, split);
	endtask
	// one note per finished frame, oldest first
	always @(negedge clock) begin
		if (word_done === 1'b1 || word_discard === 1'b1) begin
			if (notes.size() == 0) begin
				chk(22'h3FFFFF, obs);
			end else begin
				chk(notes.pop_front(), obs);
			end
		end
	end
	initial begin
		#1000000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(negedge clock);
		rst = 1'b0;
		repeat (6) @(negedge clock);
		chk(state(1'b0), obs);
		chk_ready(2'h3);
		// short and long frames leave every register alone
		notes.push_back(state(1'b1));
		h.send(32'h00007FA5, 15, 1'b0);
		notes.push_back(state(1'b1));
		h.send(32'h00013C5A, 17, 1'b0);
		for (int k = 0; k < 32; k++) begin
			rnd = lfsr(rnd);
			word({rnd[15:14], k[4], rnd[12:11], k[2], k[1:0], rnd[23:16]}, k[3]);
		end
		// recovery: full power-down then both up, then one channel only
		word(16'h1900, 1'b0);
		word(16'h0100, 1'b0);
		repeat (190) @(negedge clock);
		chk_ready(2'h0);
		repeat (100) @(negedge clock);
		chk_ready(2'h3);
		word(16'h0900, 1'b0);
		repeat (40) @(negedge clock);
		word(16'h0100, 1'b0);
		repeat (20) @(negedge clock);
		chk_ready(2'h1);
		repeat (30) @(negedge clock);
		chk_ready(2'h3);
		chk(22'h000000, {21'h000000, notes.size() != 0});
		tally_and_finish();
	end
endmodule
